// File: hdl/host_port.sv
// Host mailbox port: asynchronous parallel host side, core data-memory side.
// Assumes host strobes and data are held several core clocks per phase.
//
// Behaviour
// - Host pins carry no clock; all are synchronised into core domain.
// - Host writes land any time; neither host nor core ever stalls.
// - Width strap selects 8-bit or 16-bit host transfers.
// - Strobe strap: separate read/write strobes, or read/write select plus strobe.
// - Bus strap: separate 3-bit address, or multiplexed bus latched by ALE.
// - Host sees a memory-mapped peripheral decoded from address and strobes.
// - Six data mailboxes, two status registers, one mailbox interrupt mask.
// - Core reaches the mailboxes as words in its data memory window.
// - Host and core read identical status registers.
// - Upper status holds a soft reset bit settable by host or core.
// - Host write to any mailbox raises a write interrupt request.
// - Completed host read of any mailbox raises a read interrupt request.
// - Per-mailbox read and write state is kept in status registers.
// - Mask holds separate read and write bits for each mailbox.
// - Interrupt reaches core only if mailbox mask and global enable set.
// - Interrupts and polling work together on the same flags.
// - In host boot, host-written words go automatically into program memory.
// - Boot strap selects host-port boot or external byte-wide memory boot.
// - Mailbox interrupts cannot be forced or cleared by core software.
`timescale 1ns/1ns
module host_port (
	input  wire logic                                   clk_i,
	input  wire logic                                   sys_rst_i,
	input  wire logic                                   host_cs_n_i,
	input  wire logic                                   host_strobe_a_n_i,
	input  wire logic                                   host_strobe_b_n_i,
	input  wire logic                                   host_ale_i,
	input  wire logic [host_port_pkg::HADDR_W-1:0]      host_addr_i,
	input  wire logic [host_port_pkg::DATA_W-1:0]       host_data_i,
	output logic      [host_port_pkg::DATA_W-1:0]       host_data_o,
	output logic                                        host_data_oe_o,
	input  wire logic                                   width_sel_i,
	input  wire logic                                   strobe_mode_select_i,
	input  wire logic                                   bus_mux_select_i,
	input  wire logic                                   boot_source_select_i,
	input  wire logic                                   core_sel_i,
	input  wire logic                                   core_rd_i,
	input  wire logic                                   core_wr_i,
	input  wire logic [host_port_pkg::CADDR_W-1:0]      core_addr_i,
	input  wire logic [host_port_pkg::DATA_W-1:0]       core_wdata_i,
	output logic      [host_port_pkg::DATA_W-1:0]       core_rdata_o,
	input  wire logic                                   core_write_irq_en_i,
	input  wire logic                                   core_read_irq_en_i,
	output logic                                        host_write_irq_o,
	output logic                                        host_read_irq_o,
	output logic                                        soft_reset_o,
	output logic                                        pm_we_o,
	output logic      [host_port_pkg::PM_ADDR_W-1:0]    pm_addr_o,
	output logic      [host_port_pkg::INSTR_W-1:0]      pm_data_o,
	output logic                                        boot_busy_o,
	output logic                                        boot_done_o,
	output logic                                        ext_boot_req_o
);

	localparam int NM = host_port_pkg::NUM_MBOX;
	localparam int DW = host_port_pkg::DATA_W;
	localparam int BW = host_port_pkg::BYTE_W;
	localparam int AW = host_port_pkg::HADDR_W;

	typedef struct packed {
		logic              straps_ok;
		logic [2:0]        strap_cnt;
		logic              width16;
		logic              strobe_rw;
		logic              bus_mux;
		logic              boot_host;
		logic              boot_start;
		logic              prev_act;
		logic [AW-1:0]     addr_lat;
		logic [AW-1:0]     cur_addr;
		logic              cur_wr;
		logic [DW-1:0]     data_cap;
		logic              byte_hi;
		logic [BW-1:0]     lo_byte;
		logic [NM-1:0][DW-1:0] mbox;
		logic [NM-1:0]     wflag;
		logic [NM-1:0]     rflag;
		logic [NM-1:0]     wmask;
		logic [NM-1:0]     rmask;
		logic              soft_rst;
		logic              srst_out;
		logic              irq_wr;
		logic              irq_rd;
		logic              boot_load;
		logic [DW-1:0]     host_dout;
		logic              host_doe;
		logic [DW-1:0]     core_rdata;
	} port_state_type;

	port_state_type s_ff;
	port_state_type nxt_s;

	logic [host_port_pkg::SYNC_W-1:0] pins;
	logic                             busy;
	logic                             done;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic is_mbox(input logic [3:0] a);
		is_mbox = (a < 4'(NM));
	endfunction

	function automatic logic [NM-1:0] mbox_sel(input logic [3:0] a);
		mbox_sel = is_mbox(a) ? NM'(1) << a : '0;
	endfunction

	// Status words seen identically by host and core
	function automatic logic [DW-1:0] lstat_word(input port_state_type s);
		lstat_word = host_port_pkg::WORD_ZERO;
		lstat_word[host_port_pkg::WFLD_LSB +: NM] = s.wflag;
		lstat_word[host_port_pkg::RFLD_LSB +: NM] = s.rflag;
	endfunction

	function automatic logic [DW-1:0] ustat_word(input port_state_type s,
		input logic bsy, input logic dn);
		ustat_word = host_port_pkg::WORD_ZERO;
		ustat_word[host_port_pkg::USTAT_SRST]    = s.soft_rst;
		ustat_word[host_port_pkg::USTAT_BUSY]    = bsy;
		ustat_word[host_port_pkg::USTAT_DONE]    = dn;
		ustat_word[host_port_pkg::USTAT_BYTE_HI] = s.byte_hi;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and boot loader

	pin_sync #(
		.W       (host_port_pkg::SYNC_W),
		.RST_VAL (host_port_pkg::PIN_IDLE)
	) u_sync (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.pin_i     ({boot_source_select_i, bus_mux_select_i,
			strobe_mode_select_i, width_sel_i, host_ale_i, host_cs_n_i,
			host_strobe_a_n_i, host_strobe_b_n_i, host_addr_i,
			host_data_i}),
		.flt_o     (pins)
	);

	boot_loader u_boot (
		.clk_i          (clk_i),
		.sys_rst_i      (sys_rst_i),
		.start_i        (s_ff.boot_start),
		.host_boot_i    (s_ff.boot_host),
		.load_i         (s_ff.boot_load),
		.lo_word_i      (s_ff.mbox[host_port_pkg::BOOT_LO_REG]),
		.hi_word_i      (s_ff.mbox[host_port_pkg::BOOT_HI_REG]),
		.pm_we_o        (pm_we_o),
		.pm_addr_o      (pm_addr_o),
		.pm_data_o      (pm_data_o),
		.boot_busy_o    (busy),
		.boot_done_o    (done),
		.ext_boot_req_o (ext_boot_req_o)
	);

	////////////////////////////////////////////////////////////////////////
	// Next-state logic

	always_comb begin
		logic              act;
		logic              is_wr;
		logic              start;
		logic              fin;
		logic [AW-1:0]     haddr;
		logic [DW-1:0]     hword;
		logic [DW-1:0]     wdata;
		logic              commit;
		logic [NM-1:0]     wevt;
		logic [NM-1:0]     revt;
		logic [NM-1:0]     csel;
		logic [NM-1:0]     crd_clr;
		logic [NM-1:0]     cwr_clr;
		logic              srst_req;

		act      = 1'b0;
		is_wr    = 1'b0;
		start    = 1'b0;
		fin      = 1'b0;
		haddr    = '0;
		hword    = host_port_pkg::WORD_ZERO;
		wdata    = host_port_pkg::WORD_ZERO;
		commit   = 1'b0;
		wevt     = '0;
		revt     = '0;
		csel     = mbox_sel(core_addr_i);
		crd_clr  = '0;
		cwr_clr  = '0;
		srst_req = 1'b0;

		nxt_s            = s_ff;
		nxt_s.boot_start = 1'b0;
		nxt_s.boot_load  = 1'b0;
		nxt_s.srst_out   = 1'b0;

		// Straps are caught once the synchroniser has settled after reset
		if (!s_ff.straps_ok) begin
			nxt_s.strap_cnt = s_ff.strap_cnt + 1'b1;
			if (s_ff.strap_cnt == host_port_pkg::STRAP_SETTLE) begin
				nxt_s.straps_ok  = 1'b1;
				nxt_s.width16    = pins[host_port_pkg::PIN_WIDTH];
				nxt_s.strobe_rw  = pins[host_port_pkg::PIN_STROBE];
				nxt_s.bus_mux    = pins[host_port_pkg::PIN_BUSMUX];
				nxt_s.boot_host  = pins[host_port_pkg::PIN_BOOT];
				nxt_s.boot_start = 1'b1;
			end
		end

		// Strobe decode; in select mode strobe A is read-high/write-low
		if (s_ff.strobe_rw) begin
			act   = !pins[host_port_pkg::PIN_SB_N];
			is_wr = !pins[host_port_pkg::PIN_SA_N];
		end else begin
			act   = !pins[host_port_pkg::PIN_SA_N] ||
				!pins[host_port_pkg::PIN_SB_N];
			is_wr = !pins[host_port_pkg::PIN_SB_N];
		end
		act   = act && s_ff.straps_ok && !pins[host_port_pkg::PIN_CS_N];
		start = act && !s_ff.prev_act;
		fin   = !act && s_ff.prev_act;
		nxt_s.prev_act = act;

		// Transparent address latch while ALE is high
		if (s_ff.bus_mux && pins[host_port_pkg::PIN_ALE]) begin
			nxt_s.addr_lat = pins[host_port_pkg::PIN_DATA_LSB +: AW];
		end
		if (start) begin
			nxt_s.cur_addr = s_ff.bus_mux ? s_ff.addr_lat :
				pins[host_port_pkg::PIN_ADDR_LSB +: AW];
			nxt_s.cur_wr   = is_wr;
		end
		if (act) begin
			nxt_s.data_cap = pins[host_port_pkg::PIN_DATA_LSB +: DW];
		end

		// Host read data, driven only during a read strobe
		haddr = nxt_s.cur_addr;
		if (haddr == host_port_pkg::HADDR_LSTAT) begin
			hword = lstat_word(s_ff);
		end else if (haddr == host_port_pkg::HADDR_USTAT) begin
			hword = ustat_word(s_ff, busy, done);
		end else begin
			hword = s_ff.mbox[haddr];
		end
		nxt_s.host_doe = act && !nxt_s.cur_wr;
		if (s_ff.width16) begin
			nxt_s.host_dout = hword;
		end else begin
			nxt_s.host_dout = {{BW{1'b0}},
				s_ff.byte_hi ? hword[DW-1:BW] : hword[BW-1:0]};
		end

		// End of host access; 8-bit mode pairs low byte then high byte
		if (fin) begin
			commit = s_ff.width16 || s_ff.byte_hi;
			if (!s_ff.width16) begin
				nxt_s.byte_hi = !s_ff.byte_hi;
			end
			if (s_ff.cur_wr && !s_ff.width16 && !s_ff.byte_hi) begin
				nxt_s.lo_byte = s_ff.data_cap[BW-1:0];
			end
			wdata = s_ff.width16 ? s_ff.data_cap :
				{s_ff.data_cap[BW-1:0], s_ff.lo_byte};
			if (commit && s_ff.cur_wr) begin
				wevt = mbox_sel({1'b0, s_ff.cur_addr});
				if (s_ff.cur_addr == host_port_pkg::HADDR_USTAT) begin
					srst_req = wdata[host_port_pkg::USTAT_SRST];
				end
			end else if (commit) begin
				revt = mbox_sel({1'b0, s_ff.cur_addr});
			end
		end

		// Core access, single cycle, never waits on the host
		if (core_sel_i && core_wr_i) begin
			cwr_clr = csel;
			for (int i = 0; i < NM; i++) begin
				if (csel[i] && !wevt[i]) begin
					nxt_s.mbox[i] = core_wdata_i;
				end
			end
			if (core_addr_i == host_port_pkg::CIDX_USTAT) begin
				srst_req = srst_req ||
					core_wdata_i[host_port_pkg::USTAT_SRST];
			end
			if (core_addr_i == host_port_pkg::CIDX_MASK) begin
				nxt_s.wmask = core_wdata_i[host_port_pkg::WFLD_LSB +: NM];
				nxt_s.rmask = core_wdata_i[host_port_pkg::RFLD_LSB +: NM];
			end
		end
		if (core_sel_i && core_rd_i) begin
			crd_clr = csel;
			if (is_mbox(core_addr_i)) begin
				nxt_s.core_rdata = s_ff.mbox[core_addr_i[AW-1:0]];
			end else if (core_addr_i == host_port_pkg::CIDX_LSTAT) begin
				nxt_s.core_rdata = lstat_word(s_ff);
			end else if (core_addr_i == host_port_pkg::CIDX_USTAT) begin
				nxt_s.core_rdata = ustat_word(s_ff, busy, done);
			end else if (core_addr_i == host_port_pkg::CIDX_MASK) begin
				nxt_s.core_rdata = host_port_pkg::WORD_ZERO;
				nxt_s.core_rdata[host_port_pkg::WFLD_LSB +: NM] = s_ff.wmask;
				nxt_s.core_rdata[host_port_pkg::RFLD_LSB +: NM] = s_ff.rmask;
			end else begin
				nxt_s.core_rdata = host_port_pkg::WORD_ZERO;
			end
		end

		// Host write wins over a same-cycle core write to one mailbox
		for (int i = 0; i < NM; i++) begin
			if (wevt[i]) begin
				nxt_s.mbox[i] = wdata;
			end
		end

		// Hardware set wins over the core's clearing access
		nxt_s.wflag = (s_ff.wflag & ~crd_clr) | wevt;
		nxt_s.rflag = (s_ff.rflag & ~cwr_clr) | revt;

		// Requests derive only from host events, masks and global enables: no software force
		nxt_s.irq_wr = core_write_irq_en_i && |(wevt & s_ff.wmask);
		nxt_s.irq_rd = core_read_irq_en_i && |(revt & s_ff.rmask);

		if (s_ff.boot_host && wevt[host_port_pkg::BOOT_HI_REG]) begin
			nxt_s.boot_load = 1'b1;
		end

		// Soft reset holds one cycle, then wipes mailbox state
		if (s_ff.soft_rst) begin
			nxt_s.soft_rst = 1'b0;
			nxt_s.srst_out = 1'b1;
			nxt_s.mbox     = '0;
			nxt_s.wflag    = '0;
			nxt_s.rflag    = '0;
			nxt_s.byte_hi  = 1'b0;
		end else if (srst_req) begin
			nxt_s.soft_rst = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs; polling and interrupts share the same flags
	assign host_data_o      = s_ff.host_dout;
	assign host_data_oe_o   = s_ff.host_doe;
	assign core_rdata_o     = s_ff.core_rdata;
	assign host_write_irq_o = s_ff.irq_wr;
	assign host_read_irq_o  = s_ff.irq_rd;
	assign soft_reset_o     = s_ff.srst_out;
	assign boot_busy_o      = busy;
	assign boot_done_o      = done;

endmodule

// File: hdl/host_port_pkg.sv
// Constants, field layout and types shared by the host mailbox port.
// Assumes a single 10 MHz core clock and a 16-bit core data path.
package host_port_pkg;

	////////////////////////////////////////////////////////////////////////
	// Widths
	localparam int DATA_W    = 16;
	localparam int BYTE_W    = 8;
	localparam int HADDR_W   = 3;
	localparam int CADDR_W   = 4;
	localparam int NUM_MBOX  = 6;
	localparam int INSTR_W   = 24;
	localparam int PM_ADDR_W = 11;
	localparam int SYNC_W    = 27;

	////////////////////////////////////////////////////////////////////////
	// Host-side register addresses (0..5 are the data mailboxes)
	localparam logic [HADDR_W-1:0] HADDR_LSTAT = 3'h6;
	localparam logic [HADDR_W-1:0] HADDR_USTAT = 3'h7;

	// Core-side word indices inside the data memory window
	localparam logic [CADDR_W-1:0] CIDX_LSTAT = 4'h6;
	localparam logic [CADDR_W-1:0] CIDX_USTAT = 4'h7;
	localparam logic [CADDR_W-1:0] CIDX_MASK  = 4'h8;

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int WFLD_LSB      = 0;
	localparam int RFLD_LSB      = 8;
	localparam int USTAT_BUSY    = 0;
	localparam int USTAT_DONE    = 1;
	localparam int USTAT_BYTE_HI = 2;
	localparam int USTAT_SRST    = 7;

	////////////////////////////////////////////////////////////////////////
	// Synchroniser bundle layout and its idle value
	localparam int PIN_DATA_LSB = 0;
	localparam int PIN_ADDR_LSB = 16;
	localparam int PIN_SB_N     = 19;
	localparam int PIN_SA_N     = 20;
	localparam int PIN_CS_N     = 21;
	localparam int PIN_ALE      = 22;
	localparam int PIN_WIDTH    = 23;
	localparam int PIN_STROBE   = 24;
	localparam int PIN_BUSMUX   = 25;
	localparam int PIN_BOOT     = 26;
	localparam logic [SYNC_W-1:0] PIN_IDLE = 27'h38_0000;

	////////////////////////////////////////////////////////////////////////
	// Reset values and timing
	localparam logic [DATA_W-1:0] WORD_ZERO    = 16'h0000;
	// Synchroniser output is valid only after the fourth edge out of reset
	localparam logic [2:0]        STRAP_SETTLE = 3'h4;

	// Boot loader
	localparam logic [PM_ADDR_W-1:0] BOOT_LAST = 11'h7ff;
	localparam int                   BOOT_LO_REG = 0;
	localparam int                   BOOT_HI_REG = 1;

	typedef enum logic [1:0] {
		BOOT_IDLE,
		BOOT_LOAD,
		BOOT_DONE
	} boot_state_type;

endpackage

// File: hdl/pin_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes pins are quasi-static across a few core clocks per change.
`timescale 1ns/1ns
module pin_sync #(
	parameter int           W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk_i,
	input  wire logic         sys_rst_i,
	input  wire logic [W-1:0] pin_i,
	output logic      [W-1:0] flt_o
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] flt;
	} sync_state_type;

	sync_state_type s_ff;
	sync_state_type nxt_s;

	////////////////////////////////////////////////////////////////////////
	// First stage feeds only the second; update once stages two and three agree
	always_comb begin
		nxt_s     = s_ff;
		nxt_s.s1  = pin_i;
		nxt_s.s2  = s_ff.s1;
		nxt_s.s3  = s_ff.s2;
		nxt_s.flt = (s_ff.s2 & s_ff.s3) | (s_ff.flt & (s_ff.s2 | s_ff.s3));
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			s_ff <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign flt_o = s_ff.flt;

endmodule

// File: hdl/boot_loader.sv
// Moves host-written instruction words from the mailbox into program memory.
// Assumes a one-cycle load pulse when the high part of a word is written.
`timescale 1ns/1ns
module boot_loader (
	input  wire logic                                  clk_i,
	input  wire logic                                  sys_rst_i,
	input  wire logic                                  start_i,
	input  wire logic                                  host_boot_i,
	input  wire logic                                  load_i,
	input  wire logic [host_port_pkg::DATA_W-1:0]      lo_word_i,
	input  wire logic [host_port_pkg::DATA_W-1:0]      hi_word_i,
	output logic                                       pm_we_o,
	output logic      [host_port_pkg::PM_ADDR_W-1:0]   pm_addr_o,
	output logic      [host_port_pkg::INSTR_W-1:0]     pm_data_o,
	output logic                                       boot_busy_o,
	output logic                                       boot_done_o,
	output logic                                       ext_boot_req_o
);

	typedef struct packed {
		host_port_pkg::boot_state_type           st;
		logic [host_port_pkg::PM_ADDR_W-1:0]     addr;
		logic [host_port_pkg::INSTR_W-1:0]       data;
		logic                                    we;
		logic                                    ext;
	} boot_s_type;

	boot_s_type s_ff;
	boot_s_type nxt_s;

	always_comb begin
		nxt_s    = s_ff;
		nxt_s.we = 1'b0;
		case (s_ff.st)
			host_port_pkg::BOOT_IDLE: begin
				if (start_i && host_boot_i) begin
					nxt_s.st = host_port_pkg::BOOT_LOAD;
				end else if (start_i) begin
					nxt_s.ext = 1'b1;
					nxt_s.st  = host_port_pkg::BOOT_DONE;
				end
			end
			host_port_pkg::BOOT_LOAD: begin
				if (s_ff.we) begin
					nxt_s.addr = s_ff.addr + 1'b1;
					if (s_ff.addr == host_port_pkg::BOOT_LAST) begin
						nxt_s.st = host_port_pkg::BOOT_DONE;
					end
				end else if (load_i) begin
					nxt_s.data = {hi_word_i[host_port_pkg::BYTE_W-1:0],
						lo_word_i};
					nxt_s.we   = 1'b1;
				end
			end
			host_port_pkg::BOOT_DONE: begin
				nxt_s.ext = s_ff.ext;
			end
			default: begin
				nxt_s.st = host_port_pkg::BOOT_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			s_ff <= '{st: host_port_pkg::BOOT_IDLE, default: '0};
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign pm_we_o        = s_ff.we;
	assign pm_addr_o      = s_ff.addr;
	assign pm_data_o      = s_ff.data;
	assign boot_busy_o    = (s_ff.st == host_port_pkg::BOOT_LOAD);
	assign boot_done_o    = (s_ff.st == host_port_pkg::BOOT_DONE);
	assign ext_boot_req_o = s_ff.ext;

endmodule

// File: testbench/host_port_asserts.sv
// Pin-level checks for the host mailbox port.
// Assumes it is bound onto host_port, which runs on one core clock.
`timescale 1ns/1ns
module host_port_asserts (
	input wire logic        clk_i,
	input wire logic        sys_rst_i,
	input wire logic        host_cs_n_i,
	input wire logic        width_sel_i,
	input wire logic        core_sel_i,
	input wire logic        core_rd_i,
	input wire logic [3:0]  core_addr_i,
	input wire logic [15:0] core_rdata_o,
	input wire logic        core_write_irq_en_i,
	input wire logic        core_read_irq_en_i,
	input wire logic        host_write_irq_o,
	input wire logic        host_read_irq_o,
	input wire logic        soft_reset_o,
	input wire logic [15:0] host_data_o,
	input wire logic        host_data_oe_o,
	input wire logic        boot_busy_o,
	input wire logic        ext_boot_req_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	sequence unmapped_rd_s;
		core_sel_i && core_rd_i && core_addr_i > host_port_pkg::CIDX_MASK;
	endsequence
	// Request is registered, so the enable that gated it is a cycle old
	wr_irq_gate_a: assert property (
		host_write_irq_o |-> $past(core_write_irq_en_i))
		else $error("write irq while globally disabled");
	rd_irq_gate_a: assert property (
		host_read_irq_o |-> $past(core_read_irq_en_i))
		else $error("read irq while globally disabled");
	wr_irq_pulse_a: assert property (host_write_irq_o |=> !host_write_irq_o)
		else $error("write irq longer than one cycle");
	rd_irq_pulse_a: assert property ($rose(host_read_irq_o) |=> $fell(host_read_irq_o))
		else $error("read irq longer than one cycle");
	srst_pulse_a: assert property (soft_reset_o |=> !soft_reset_o)
		else $error("soft reset pulse too long");
	unmapped_read_a: assert property (unmapped_rd_s |=> core_rdata_o == 16'h0000)
		else $error("unmapped core read not zero");
	byte_lane_a: assert property (host_data_oe_o && !width_sel_i |-> host_data_o[15:8] == 8'h00)
		else $error("upper byte driven in byte mode");
	oe_select_a: assert property ($rose(host_data_oe_o) |-> !host_cs_n_i)
		else $error("data driven without chip select");
	ext_boot_a: assert property (ext_boot_req_o |-> !boot_busy_o)
		else $error("host boot busy during external boot");
endmodule
bind host_port host_port_asserts u_chk (.*);

// File: testbench/host_bus_model.sv
// Behavioural host processor driving the asynchronous mailbox port.
// Assumes each bus phase lasts six core clocks (eight after release), above the five needed.
`timescale 1ns/1ns
module host_bus_model (
	input  wire logic        clk_i,
	input  wire logic        strobe_mode_i,
	input  wire logic        bus_mux_i,
	input  wire logic        width_i,
	input  wire logic [15:0] data_i,
	output logic             cs_n_o,
	output logic             sa_n_o,
	output logic             sb_n_o,
	output logic             ale_o,
	output logic [2:0]       addr_o,
	output logic [15:0]      data_o
);
	initial begin
		{cs_n_o, sa_n_o, sb_n_o, ale_o} = 4'h e;
		addr_o = 3'h0;
		data_o = 16'hffff;
	end
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic acc(input logic wr, input logic [2:0] a,
			input logic [15:0] d, output logic [15:0] q);
		if (bus_mux_i) begin
			data_o = {13'h0000, a};
			addr_o = ~a;
			ale_o = 1'b1;
			wait_n(6);
			ale_o = 1'b0;
			wait_n(6);
		end else
			addr_o = a;
		cs_n_o = 1'b0;
		data_o = wr ? d : ~data_o;
		sa_n_o = strobe_mode_i ? !wr : wr;
		sb_n_o = strobe_mode_i ? 1'b0 : !wr;
		wait_n(6);
		q = data_i;
		{cs_n_o, sa_n_o, sb_n_o} = 3'h7;
		// Released bus shows a changed pattern, not stale data
		data_o = ~data_o;
		wait_n(8);
	endtask
	task automatic xfer(input logic wr, input logic [2:0] a,
			input logic [15:0] d, output logic [15:0] q);
		logic [15:0] lo;
		if (width_i)
			acc(wr, a, d, q);
		else begin
			acc(wr, a, {8'h00, d[7:0]}, lo);
			acc(wr, a, {8'h00, d[15:8]}, q);
			q = {q[7:0], lo[7:0]};
		end
	endtask
endmodule

// File: testbench/host_port_tb_top.sv
// Self-checking bench for the host mailbox port, two strap setups.
// Assumes the design package and the host bus model are compiled first.
`timescale 1ns/1ns
module host_port_tb_top;
	logic clk_i = 0, sys_rst_i = 1, host_cs_n_i, host_strobe_a_n_i;
	logic host_strobe_b_n_i, host_ale_i, host_data_oe_o, pm_we_o;
	logic [2:0] host_addr_i;
	logic [15:0] host_data_i, host_data_o, core_rdata_o;
	logic [15:0] core_wdata_i = 16'h0000;
	logic width_sel_i = 1, strobe_mode_select_i = 0, bus_mux_select_i = 0;
	logic boot_source_select_i = 0, core_sel_i = 0, core_rd_i = 0;
	logic core_wr_i = 0, core_write_irq_en_i = 1, core_read_irq_en_i = 1;
	logic [3:0] core_addr_i = 4'h0;
	logic host_write_irq_o, host_read_irq_o, soft_reset_o;
	logic boot_busy_o, boot_done_o, ext_boot_req_o, rd_tk = 0;
	logic [10:0] pm_addr_o;
	logic [23:0] pm_data_o;
	logic [15:0] exp_q[$];
	int errors = 0, n_checks = 0, wcnt = 0, rcnt = 0, scnt = 0, pcnt = 0;
	logic [23:0] pm_q[$];
	host_port uut (.*);
	host_bus_model partner (.clk_i(clk_i), .strobe_mode_i(strobe_mode_select_i),
		.bus_mux_i(bus_mux_select_i), .width_i(width_sel_i),
		.data_i(host_data_o), .cs_n_o(host_cs_n_i), .sa_n_o(host_strobe_a_n_i),
		.sb_n_o(host_strobe_b_n_i), .ale_o(host_ale_i), .addr_o(host_addr_i),
		.data_o(host_data_i));
	always #50 clk_i = ~clk_i;
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test;
		if (errors == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	function automatic logic [16:0] lfsr(input logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction
	task automatic core_wr(input logic [3:0] a, input logic [15:0] d);
		{core_sel_i, core_wr_i, core_addr_i, core_wdata_i} = {2'h3, a, d};
		@(posedge clk_i);
		#1;
		{core_sel_i, core_wr_i} = 2'h0;
		@(posedge clk_i);
		#1;
	endtask
	task automatic core_rd(input logic [3:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		{core_sel_i, core_rd_i, core_addr_i} = {2'h3, a};
		@(posedge clk_i);
		#1;
		{core_sel_i, core_rd_i} = 2'h0;
		@(posedge clk_i);
		#1;
	endtask
	// Read data is settled by the falling edge after the taking edge
	always @(posedge clk_i) rd_tk <= core_sel_i & core_rd_i;
	always @(negedge clk_i) if (rd_tk === 1'b1)
		check(core_rdata_o, exp_q.pop_front());
	always @(posedge clk_i) begin
		if (host_write_irq_o === 1'b1) wcnt <= wcnt + 1;
		if (host_read_irq_o === 1'b1) rcnt <= rcnt + 1;
		if (soft_reset_o === 1'b1) scnt <= scnt + 1;
		if (pm_we_o === 1'b1) pcnt <= pcnt + 1;
	end
	always @(posedge clk_i) if (pm_we_o === 1'b1)
		check(pm_data_o, pm_q.pop_front());
	initial begin
		#3_000_000;
		errors++;
		end_of_test();
	end
	initial begin
		logic [15:0] d, q;
		logic [16:0] s;
		logic [23:0] pm_exp;
		int n;
		s = 17'h1_10c5;
		for (int cfg = 0; cfg < 2; cfg++) begin
			sys_rst_i = 1;
			{width_sel_i, strobe_mode_select_i, bus_mux_select_i,
				boot_source_select_i} = cfg ? 4'h7 : 4'h8;
			repeat (12) @(posedge clk_i);
			#1;
			sys_rst_i = 0;
			repeat (20) @(posedge clk_i);
			#1;
			check(ext_boot_req_o, !boot_source_select_i);
			check(boot_done_o, !boot_source_select_i);
			check(boot_busy_o, boot_source_select_i);
			core_wr(4'h8, 16'h3f3f);
			core_rd(4'h8, 16'h3f3f);
			for (int k = 0; k < 6; k++) begin
				s = lfsr(s);
				d = s[15:0];
				// Boot word: mailbox 1 low byte over mailbox 0
				pm_exp = {d[7:0], k ? pm_exp[15:0] : ~d};
				if (k == 1 && boot_source_select_i)
					pm_q.push_back(pm_exp);
				n = wcnt;
				partner.xfer(1, k[2:0], d, q);
				check(24'(wcnt - n), 1);
				core_rd(4'h6, 16'h0001 << k);
				core_rd(k[3:0], d);
				core_rd(4'h6, 16'h0000);
				n = rcnt;
				partner.xfer(0, k[2:0], 16'h0000, q);
				check(q, d);
				check(24'(rcnt - n), 1);
				core_rd(4'h6, 16'h0100 << k);
				core_wr(k[3:0], ~d);
				core_rd(4'h6, 16'h0000);
			end
			n = wcnt;
			core_wr(4'h8, 16'h3f3e);
			partner.xfer(1, 3'h0, d, q);
			check(24'(wcnt - n), 0);
			core_wr(4'h8, 16'h3f3f);
			core_write_irq_en_i = 0;
			partner.xfer(1, 3'h0, d, q);
			check(24'(wcnt - n), 0);
			{core_write_irq_en_i, core_read_irq_en_i} = 2'h2;
			n = rcnt;
			partner.xfer(0, 3'h0, 16'h0000, q);
			check(q, d);
			check(24'(rcnt - n), 0);
			core_read_irq_en_i = 1;
			core_rd(4'h6, 16'h0101);
			if (width_sel_i) begin
				partner.xfer(0, 3'h6, 16'h0000, q);
				check(q, 16'h0101);
			end
			n = scnt;
			partner.xfer(1, 3'h7, 16'h0080, q);
			check(24'(scnt - n), 1);
			core_rd(4'h6, 16'h0000);
			core_rd(4'h8, 16'h3f3f);
			core_wr(4'h7, 16'h0080);
			repeat (4) @(posedge clk_i);
			#1;
			check(24'(scnt - n), 2);
			core_rd(4'hf, 16'h0000);
			check(24'(pcnt), 24'(boot_source_select_i));
			check(24'(pm_addr_o), 24'(boot_source_select_i));
		end
		end_of_test();
	end
endmodule
